// *** hdl/trap_pkg.sv ***
/*
 Shared constants and carrier types for the I/O trap NMI unit.
 Assumes a single clock domain and an AXI4-Lite register slave.
*/
package trap_pkg;

  // ----------------------------------------------------------------
  // Register indices and address width
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_STATUS    = 8'h19;
  localparam logic [7:0]  IDX_P1_LOW    = 8'h1a;
  localparam logic [7:0]  IDX_P1_HIGH   = 8'h1b;
  localparam logic [7:0]  IDX_P2_LOW    = 8'h1c;
  localparam logic [7:0]  IDX_P2_HIGH   = 8'h1d;
  localparam logic [7:0]  IDX_P3_LOW    = 8'h1e;
  localparam logic [7:0]  IDX_P3_HIGH   = 8'h1f;
  localparam logic [7:0]  IDX_NMI_MASK  = 8'hc4;
  localparam logic [7:0]  IDX_IRQ_STAT  = 8'h40;
  localparam logic [7:0]  IDX_IRQ_EN    = 8'h41;
  localparam logic [7:0]  IDX_IRQ_CLR   = 8'h42;
  localparam logic [7:0]  IDX_LATCH_SRC = 8'h43;
  localparam int          ADDR_W        = 12;

  // ----------------------------------------------------------------
  // Field positions, reset values and AXI response codes
  // ----------------------------------------------------------------
  localparam int          MODE_POS      = 6;
  localparam int          SIZE_POS      = 4;
  localparam int          ALIAS_POS     = 3;
  localparam int          SEL_POS       = 2;
  localparam int          KBD_POS       = 1;
  localparam int          PMU_POS       = 0;
  localparam logic [7:0]  LOW_RESET     = 8'h00;
  localparam logic [7:0]  HIGH_RESET    = 8'h00;
  localparam logic [1:0]  SEL_NONE      = 2'h0;
  localparam logic [1:0]  AXI_OKAY      = 2'h0;
  localparam logic [1:0]  AXI_SLVERR    = 2'h2;

  // Trap mode encodings
  localparam logic [1:0]  MODE_OFF      = 2'h0;
  localparam logic [1:0]  MODE_RD       = 2'h1;
  localparam logic [1:0]  MODE_WR       = 2'h2;
  localparam logic [1:0]  MODE_RW       = 2'h3;

  // Interrupt status bit layout
  localparam int          EV_TRAP1      = 0;
  localparam int          EV_TRAP2      = 1;
  localparam int          EV_TRAP3      = 2;
  localparam int          EV_KBD        = 3;
  localparam int          EV_PMU        = 4;
  localparam int          EV_W          = 5;

  // One trap window configuration
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] size;
    logic       alias_en;
    logic [9:0] addr;
  } window_cfg_t;

  // One observed ISA I/O cycle
  typedef struct packed {
    logic        valid;
    logic        is_write;
    logic [15:0] addr;
  } io_cycle_t;

  // Memory mapping selection
  typedef enum logic [0:0] {
    MAP_NORMAL = 1'b0,
    MAP_ROM    = 1'b1
  } map_state_t;

endpackage : trap_pkg

// *** hdl/trap_window.sv ***
/*
 One trap window comparator: matches an I/O cycle against a window.
 Assumes the cycle and configuration are stable in the same clock.
*/
`timescale 1ns/1ps
module trap_window (
  // Configuration and observed cycle
  input  wire trap_pkg::window_cfg_t cfg,
  input  wire trap_pkg::io_cycle_t   cyc,
  // Result
  output logic                       hit
);

  logic [9:0] mask;
  logic       addr_ok;
  logic       high_ok;
  logic       kind_ok;

  // Size field picks how many low bits are ignored
  always_comb begin
    case (cfg.size)
      2'h0:    mask = 10'h3fe;
      2'h1:    mask = 10'h3fc;  // R12
      2'h2:    mask = 10'h3f8;  // R12
      2'h3:    mask = 10'h3f0;  // R12
      default: mask = 10'h3fe;
    endcase
  end  // R8

  // Compare the low ten lines, upper lines only without aliasing
  assign addr_ok = ((cyc.addr[9:0] ^ cfg.addr) & mask) == 10'h000;
  assign high_ok = cfg.alias_en | (cyc.addr[15:10] == 6'h00);  // R9 R10

  // Cycle direction against the trap mode
  always_comb begin
    case (cfg.mode)
      trap_pkg::MODE_RD: kind_ok = !cyc.is_write;
      trap_pkg::MODE_WR: kind_ok = cyc.is_write;
      trap_pkg::MODE_RW: kind_ok = 1'b1;
      default:           kind_ok = 1'b0;
    endcase
  end  // R7

  assign hit = cyc.valid & kind_ok & addr_ok & high_ok;

endmodule : trap_window

// *** hdl/io_trap_nmi_unit.sv ***
/*
 I/O trap NMI unit: three port windows raise an NMI on trapped cycles.
 Assumes CPU I/O cycle strobes and NMI sources arrive on aclk.
*/
// Decided for this implementation: the AXI4-Lite register port.
// What this block does
// R1: Status bits 3:2 report pending trap: 0 none, 1..3 window number.
// R2: Writing status with a window code clears only that pending trap.
// R3: Raising an NMI latches a four-bit value into status bits 7:4.
// R4: Servicing any NMI switches mapping so the vector comes from ROM.
// R5: Reading the NMI mask register restores the pre-NMI memory mapping.
// R6: Each window holds a ten-bit address, low byte plus two bits; reset zero.
// R7: Mode field: off, trap reads, trap writes, or trap both.
// R8: Size field selects 2, 4, 8 or 16 byte window.
// R9: Without aliasing, address lines 15:10 must all be zero to match.
// R10: With aliasing, only lines 9:0 are compared.
// R11: Three windows at register pairs 1a/1b, 1c/1d, 1e/1f.
// R12: Larger windows ignore the low bits they cover, aligned to size.
// R13: Status shows keyboard and power management NMI source flags.
`timescale 1ns/1ps
module io_trap_nmi_unit (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // AXI4-Lite write address and data
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // CPU I/O cycle, one-cycle strobe
  input  wire logic        io_strobe,
  input  wire logic        io_write,
  input  wire logic [15:0] io_addr,
  // Other NMI sources, one-cycle pulses, and the nibble to latch
  input  wire logic        kbd_nmi_event,
  input  wire logic        pmu_nmi_event,
  input  wire logic [3:0]  nmi_latch_data,
  // NMI, mapping and interrupt request
  output logic             nmi,
  output logic             rom_vector_map,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0]  low_addr [3];
  logic [7:0]  high_ctrl [3];
  logic [1:0]  pending_sel;
  logic        keyboard_source_flag;
  logic        power_mgmt_source_flag;
  logic [3:0]  latched_nibble;
  logic        nmi_active;
  trap_pkg::map_state_t map_state;
  localparam int EV_W_L = trap_pkg::EV_W;
  logic [EV_W_L-1:0] irq_status;
  logic [EV_W_L-1:0] irq_enable;

  trap_pkg::window_cfg_t cfg [3];
  trap_pkg::io_cycle_t   cyc;
  logic [2:0]            hit;
  logic [1:0]            next_sel;

  // ----------------------------------------------------------------
  // Trap windows
  // ----------------------------------------------------------------
  assign cyc.valid    = io_strobe;
  assign cyc.is_write = io_write;
  assign cyc.addr     = io_addr;

  for (genvar i = 0; i < 3; i++) begin : g_win
    // Unpack each register pair into a window configuration
    assign cfg[i].mode     = high_ctrl[i][trap_pkg::MODE_POS +: 2];
    assign cfg[i].size     = high_ctrl[i][trap_pkg::SIZE_POS +: 2];
    assign cfg[i].alias_en = high_ctrl[i][trap_pkg::ALIAS_POS];
    assign cfg[i].addr     = {high_ctrl[i][1:0], low_addr[i]};  // R6
    trap_window u_win (
      .cfg (cfg[i]),
      .cyc (cyc),
      .hit (hit[i])
    );
  end

  // Lowest numbered window wins on overlap
  always_comb begin
    if (hit[0]) begin
      next_sel = 2'h1;
    end else if (hit[1]) begin
      next_sel = 2'h2;
    end else if (hit[2]) begin
      next_sel = 2'h3;
    end else begin
      next_sel = trap_pkg::SEL_NONE;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [9:0]  aw_idx;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_mapped;
  logic        rd_mapped;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic [7:0]  wbyte;
  logic [7:0]  rd_val;
  logic        status_wr;
  logic        mask_rd;
  logic        wr_ok;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire  = s_axi_arvalid && s_axi_arready;
  assign wr_idx   = aw_idx[7:0];
  assign rd_idx   = s_axi_araddr[9:2];
  assign wbyte    = wdata_q[7:0];
  assign wr_mapped = (aw_idx[9:8] == 2'h0) && (wr_idx == trap_pkg::IDX_STATUS ||
                     (wr_idx >= trap_pkg::IDX_P1_LOW && wr_idx <= trap_pkg::IDX_P3_HIGH) ||
                     wr_idx == trap_pkg::IDX_IRQ_EN || wr_idx == trap_pkg::IDX_IRQ_CLR);
  assign wr_ok     = clk_en && wr_fire && wstrb_q[0] && aw_idx[9:8] == 2'h0;  // Mapped page only
  assign status_wr = wr_ok && wr_idx == trap_pkg::IDX_STATUS;
  assign mask_rd   = clk_en && rd_fire && s_axi_araddr[11:10] == 2'h0 &&
                     rd_idx == trap_pkg::IDX_NMI_MASK;

  // Capture write address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_idx  <= 10'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_idx  <= s_axi_awaddr[11:2];
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held  <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= trap_pkg::AXI_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? trap_pkg::AXI_OKAY : trap_pkg::AXI_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux
  always_comb begin
    case (rd_idx)
      trap_pkg::IDX_STATUS:    rd_val = {latched_nibble, pending_sel,
                                         keyboard_source_flag, power_mgmt_source_flag};
      trap_pkg::IDX_P1_LOW:    rd_val = low_addr[0];
      trap_pkg::IDX_P1_HIGH:   rd_val = high_ctrl[0];
      trap_pkg::IDX_P2_LOW:    rd_val = low_addr[1];
      trap_pkg::IDX_P2_HIGH:   rd_val = high_ctrl[1];
      trap_pkg::IDX_P3_LOW:    rd_val = low_addr[2];
      trap_pkg::IDX_P3_HIGH:   rd_val = high_ctrl[2];
      trap_pkg::IDX_NMI_MASK:  rd_val = {7'h00, nmi_active};
      trap_pkg::IDX_IRQ_STAT:  rd_val = {3'h0, irq_status};
      trap_pkg::IDX_IRQ_EN:    rd_val = {3'h0, irq_enable};
      default:                 rd_val = 8'h00;
    endcase
  end
  assign rd_mapped = s_axi_araddr[11:10] == 2'h0 &&
                     (rd_idx == trap_pkg::IDX_STATUS || rd_idx == trap_pkg::IDX_NMI_MASK ||
                     (rd_idx >= trap_pkg::IDX_P1_LOW && rd_idx <= trap_pkg::IDX_P3_HIGH) ||
                     rd_idx == trap_pkg::IDX_IRQ_STAT || rd_idx == trap_pkg::IDX_IRQ_EN);

  // Read data channel, registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= trap_pkg::AXI_OKAY;
    end else if (clk_en) begin
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_mapped ? rd_val : 8'h00};
        s_axi_rresp  <= rd_mapped ? trap_pkg::AXI_OKAY : trap_pkg::AXI_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Window registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        low_addr[i]  <= trap_pkg::LOW_RESET;  // R6
        high_ctrl[i] <= trap_pkg::HIGH_RESET;
      end
    end else if (wr_ok) begin
      for (int i = 0; i < 3; i++) begin
        if (wr_idx == trap_pkg::IDX_P1_LOW + 8'(2 * i)) begin
          low_addr[i] <= wbyte;  // R11
        end
        if (wr_idx == trap_pkg::IDX_P1_HIGH + 8'(2 * i)) begin
          high_ctrl[i] <= {wbyte[7:3], 1'b0, wbyte[1:0]};  // R11
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // NMI status and source flags
  // ----------------------------------------------------------------
  logic trap_ev;
  logic any_ev;
  assign trap_ev = clk_en && next_sel != trap_pkg::SEL_NONE;
  assign any_ev  = trap_ev || (clk_en && (kbd_nmi_event || pmu_nmi_event));

  // Pending selector: new trap wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_sel <= trap_pkg::SEL_NONE;
    end else if (trap_ev) begin
      pending_sel <= next_sel;  // R1
    end else if (status_wr && wbyte[trap_pkg::SEL_POS +: 2] == pending_sel) begin
      pending_sel <= trap_pkg::SEL_NONE;  // R2
    end
  end

  // Source flags, cleared when status is written with the bit set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      keyboard_source_flag   <= 1'b0;
      power_mgmt_source_flag <= 1'b0;
    end else if (clk_en) begin
      if (kbd_nmi_event) begin
        keyboard_source_flag <= 1'b1;  // R13
      end else if (status_wr && wbyte[trap_pkg::KBD_POS]) begin
        keyboard_source_flag <= 1'b0;
      end
      if (pmu_nmi_event) begin
        power_mgmt_source_flag <= 1'b1;  // R13
      end else if (status_wr && wbyte[trap_pkg::PMU_POS]) begin
        power_mgmt_source_flag <= 1'b0;
      end
    end
  end

  // Upper nibble: latched on every NMI, not reset
  always_ff @(posedge aclk) begin
    if (any_ev) begin
      latched_nibble <= nmi_latch_data;  // R3
    end
  end

  // ----------------------------------------------------------------
  // NMI line and memory mapping
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_active <= 1'b0;
      map_state  <= trap_pkg::MAP_NORMAL;
    end else if (any_ev) begin
      nmi_active <= 1'b1;
      map_state  <= trap_pkg::MAP_ROM;  // R4
    end else if (mask_rd) begin
      nmi_active <= 1'b0;
      map_state  <= trap_pkg::MAP_NORMAL;  // R5
    end
  end
  assign nmi            = nmi_active;
  assign rom_vector_map = map_state == trap_pkg::MAP_ROM;

  // ----------------------------------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------------------------------
  logic [EV_W_L-1:0] ev_vec;
  logic [EV_W_L-1:0] clr_vec;
  assign ev_vec  = clk_en ? {pmu_nmi_event, kbd_nmi_event, hit & {3{next_sel != 2'h0}}}
                          : '0;
  assign clr_vec = (wr_ok && wr_idx == trap_pkg::IDX_IRQ_CLR)
                   ? wbyte[EV_W_L-1:0] : '0;

  // Sticky status: set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else begin
      irq_status <= (irq_status & ~clr_vec) | ev_vec;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable <= '0;
    end else if (wr_ok && wr_idx == trap_pkg::IDX_IRQ_EN) begin
      irq_enable <= wbyte[EV_W_L-1:0];
    end
  end
  assign irq = |(irq_status & irq_enable);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_trap_sets_sel: assert property (@(posedge aclk) disable iff (!aresetn)  // R1
    trap_ev |=> pending_sel == $past(next_sel))
    else $error("pending selector not loaded on trap");
  a_clear_own_sel: assert property (@(posedge aclk) disable iff (!aresetn)  // R2
    (status_wr && !trap_ev && wbyte[3:2] != pending_sel) |=> $stable(pending_sel))
    else $error("pending selector cleared by wrong code");
  a_nibble_latch: assert property (@(posedge aclk) disable iff (!aresetn)  // R3
    any_ev |=> latched_nibble == $past(nmi_latch_data))
    else $error("nibble not latched on NMI");
  a_rom_on_nmi: assert property (@(posedge aclk) disable iff (!aresetn)  // R4
    any_ev |=> nmi && rom_vector_map)
    else $error("NMI without ROM mapping");
  a_mask_restore: assert property (@(posedge aclk) disable iff (!aresetn)  // R5
    (mask_rd && !any_ev) |=> !rom_vector_map && !nmi)
    else $error("mask read did not restore mapping");
  a_mode_off: assert property (@(posedge aclk) disable iff (!aresetn)  // R7
    (high_ctrl[0][7:6] == 2'h0) |-> !hit[0])
    else $error("disabled window matched");
  a_no_alias_high: assert property (@(posedge aclk) disable iff (!aresetn)  // R9
    (hit[1] && !high_ctrl[1][3]) |-> io_addr[15:10] == 6'h00)
    else $error("unaliased window matched high address");
  a_size_align: assert property (@(posedge aclk) disable iff (!aresetn)  // R12
    (hit[2] && high_ctrl[2][5:4] == 2'h3) |-> io_addr[9:4] == {high_ctrl[2][1:0], low_addr[2][7:4]})
    else $error("sixteen byte window misaligned");

endmodule : io_trap_nmi_unit

// *** tb/cpu_io_model.sv ***
/*
 Model of the CPU side that issues ISA I/O cycles to the trap unit.
 Assumes the unit samples a one-cycle strobe on the rising edge of aclk.
*/
`timescale 1ns/1ps
module cpu_io_model (
  // Clock
  input  wire logic   aclk,
  // I/O cycle towards the trap unit
  output logic        io_strobe,
  output logic        io_write,
  output logic [15:0] io_addr
);
  // Idle bus at time zero
  initial begin
    io_strobe = 1'b0;
    io_write  = 1'b0;
    io_addr   = 16'hffff;
  end

  // One I/O cycle; released lines show the inverse so stale values never match
  task automatic io_cycle(input logic wr, input logic [15:0] addr);
    @(posedge aclk);
    io_strobe <= 1'b1;
    io_write  <= wr;
    io_addr   <= addr;
    @(posedge aclk);
    io_strobe <= 1'b0;
    io_write  <= ~wr;
    io_addr   <= ~addr;
  endtask : io_cycle
endmodule : cpu_io_model

// *** tb/io_trap_nmi_unit_tb.sv ***
/*
 Self-checking bench for the I/O trap NMI unit: AXI4-Lite master tasks,
 random trap windows and I/O cycles, keyboard and PMU sources.
 Assumes the design and cpu_io_model are compiled before this file.
*/
`timescale 1ns/1ps
module io_trap_nmi_unit_tb;
  logic        aclk, aresetn, clk_en, io_strobe, io_write, nmi, rom_vector_map, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, nmi_latch_data;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp, mode, size;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, kbd_nmi_event, pmu_nmi_event, al, wr, hit;
  logic [15:0] io_addr, addr;
  logic [9:0]  base;
  logic [7:0]  hi, en;
  int          bad_count, tests_run, k, n;

  // ----------------------------------------------------------------
  // Design, CPU model and clock
  // ----------------------------------------------------------------
  io_trap_nmi_unit u_io_trap_nmi_unit (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .io_strobe(io_strobe),
    .io_write(io_write), .io_addr(io_addr), .kbd_nmi_event(kbd_nmi_event),
    .pmu_nmi_event(pmu_nmi_event), .nmi_latch_data(nmi_latch_data), .nmi(nmi),
    .rom_vector_map(rom_vector_map), .irq(irq));
  cpu_io_model u_cpu_io_model (.aclk(aclk), .io_strobe(io_strobe), .io_write(io_write),
    .io_addr(io_addr));

  // Free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Checking, bus and closing tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // AXI4-Lite write of one register index; response lands in resp
  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= {2'b00, idx, 2'b00};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_wr

  // AXI4-Lite read of one register index into rd and resp
  task automatic axi_rd(input logic [7:0] idx);
    bit done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd

  // Expected trap decision for one window and one I/O cycle
  function automatic logic exp_hit(logic [1:0] m, logic [1:0] s, logic a, logic [9:0] b,
                                   logic w, logic [15:0] ad);
    logic [9:0] msk;
    msk = 10'h3ff << (int'(s) + 1);
    return (w ? m[1] : m[0]) && ((ad[9:0] & msk) == (b & msk)) && (a || ad[15:10] == 6'h00);
  endfunction : exp_hit

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // Watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0; clk_en = 1'b1; s_axi_awaddr = 12'h000; s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0; s_axi_wstrb = 4'hf; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_araddr = 12'h000; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    kbd_nmi_event = 1'b0; pmu_nmi_event = 1'b0; nmi_latch_data = 4'h0;
    void'($urandom(38162));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and an unmapped index
    for (k = 8'h1a; k <= 8'h1f; k++) begin
      axi_rd(8'(k));
      check("window reg reset", rd, 32'h0);
    end
    axi_rd(trap_pkg::IDX_STATUS);
    check("status reset", rd[3:0], 32'h0);
    axi_rd(trap_pkg::IDX_LATCH_SRC);
    check("unmapped resp", resp, trap_pkg::AXI_SLVERR);
    check("unmapped data", rd, 32'h0);
    axi_wr(trap_pkg::IDX_LATCH_SRC, 8'hff);
    check("unmapped write resp", resp, trap_pkg::AXI_SLVERR);
    $display("test reset done");
    // Random windows, every mode on every window, clear and restore each NMI
    for (k = 0; k < 48; k++) begin
      n = 1 + k % 3;
      mode = 2'(k / 3);
      size = 2'($urandom);
      al = 1'($urandom);
      base = 10'($urandom);
      wr = 1'($urandom);
      addr = {(($urandom % 3 == 0) ? 6'($urandom) : 6'h00), base ^ 10'($urandom % 32)};
      hi = {mode, size, al, 1'b0, base[9:8]};
      en = 8'($urandom % 32);
      hit = exp_hit(mode, size, al, base, wr, addr);
      axi_wr(trap_pkg::IDX_IRQ_EN, en);
      axi_wr(8'(8'h18 + 2 * n), base[7:0]);
      axi_wr(8'(8'h19 + 2 * n), hi);
      check("write resp", resp, trap_pkg::AXI_OKAY);
      axi_rd(8'(8'h19 + 2 * n));
      check("high readback", rd, {24'h0, hi});
      check("read resp", resp, trap_pkg::AXI_OKAY);
      nmi_latch_data <= 4'($urandom);
      u_cpu_io_model.io_cycle(wr, addr);
      @(negedge aclk);
      check("nmi", nmi, hit);
      check("rom map", rom_vector_map, hit);
      check("irq", irq, hit && en[n - 1]);
      axi_rd(trap_pkg::IDX_STATUS);
      check("pending code", rd[3:2], hit ? n : 0);
      if (hit) check("latched nibble", rd[7:4], nmi_latch_data);
      axi_rd(trap_pkg::IDX_IRQ_STAT);
      check("irq status", rd[4:0], hit ? (1 << (n - 1)) : 0);
      if (hit) begin
        axi_wr(trap_pkg::IDX_STATUS, 8'((n % 3 + 1) << 2));
        axi_rd(trap_pkg::IDX_STATUS);
        check("wrong code kept", rd[3:2], n);
        axi_wr(trap_pkg::IDX_STATUS, 8'(n << 2));
        axi_rd(trap_pkg::IDX_STATUS);
        check("right code clears", rd[3:2], 0);
        axi_rd(trap_pkg::IDX_NMI_MASK);
        check("mask read", rd[0], 1'b1);
        @(negedge aclk);
        check("nmi served", {nmi, rom_vector_map}, 2'b00);
      end
      axi_wr(trap_pkg::IDX_IRQ_CLR, 8'h1f);
      @(negedge aclk);
      check("irq cleared", irq, 1'b0);
      axi_wr(8'(8'h19 + 2 * n), 8'h00);
    end
    $display("test trap windows done");
    // Keyboard and power management sources
    for (k = 0; k < 2; k++) begin
      axi_wr(trap_pkg::IDX_IRQ_EN, 8'h18);
      @(posedge aclk);
      if (k == 0) kbd_nmi_event <= 1'b1;
      else pmu_nmi_event <= 1'b1;
      @(posedge aclk);
      kbd_nmi_event <= 1'b0;
      pmu_nmi_event <= 1'b0;
      @(negedge aclk);
      check("source map", {nmi, rom_vector_map, irq}, 3'b111);
      axi_rd(trap_pkg::IDX_STATUS);
      check("source flag", rd[1:0], k ? 2'b01 : 2'b10);
      axi_wr(trap_pkg::IDX_STATUS, k ? 8'h01 : 8'h02);
      axi_rd(trap_pkg::IDX_STATUS);
      check("source flag clear", rd[1:0], 2'b00);
      axi_rd(trap_pkg::IDX_NMI_MASK);
      axi_wr(trap_pkg::IDX_IRQ_CLR, 8'h1f);
      @(negedge aclk);
      check("source done", {nmi, rom_vector_map, irq}, 3'b000);
    end
    $display("test other sources done");
    // Clock enable low freezes the unit: a source pulse is ignored
    @(posedge aclk);
    clk_en        <= 1'b0;
    kbd_nmi_event <= 1'b1;
    @(posedge aclk);
    clk_en        <= 1'b1;
    kbd_nmi_event <= 1'b0;
    @(negedge aclk);
    check("frozen source", {nmi, rom_vector_map, irq}, 3'b000);
    axi_rd(trap_pkg::IDX_STATUS);
    check("frozen flag", rd[1:0], 2'b00);
    $display("test clock enable done");
    finish_test();
  end
endmodule : io_trap_nmi_unit_tb
